// File: hdl/bdsp_top.sv
// Background debug serial port: link framing, command decode, sequencing.
`default_nettype none
module bdsp_top
  import bdsp_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // serial link
  input wire logic serial_debug_clock,
  input wire logic serial_debug_input,
  output logic serial_debug_output,
  // processor state
  input wire logic cpu_halted,
  output logic resume_pulse,
  // access request toward core, bus and debug unit
  output logic req_valid,
  output bdsp_kind_t req_kind,
  output logic [31:0] req_addr,
  output logic [31:0] req_wdata,
  output logic [1:0] req_size,
  output logic [7:0] req_sel,
  // access answer
  input wire logic req_done,
  input wire logic req_error,
  input wire logic [31:0] req_rdata
);

  // -------------------------------------------------------------------
  // bit phase
  // -------------------------------------------------------------------
  logic take;
  logic drive;
  logic bit_in;

  bdsp_bit_sync #(
    .SYNC_STAGES(SYNC_STAGES)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .serial_debug_clock(serial_debug_clock),
    .serial_debug_input(serial_debug_input),
    .take(take),
    .drive(drive),
    .bit_value(bit_in)
  );

  // -------------------------------------------------------------------
  // framing
  // -------------------------------------------------------------------
  logic [14:0] rx_shift;
  logic [4:0] bit_cnt;
  logic [16:0] tx_shift;

  wire packet_end = take && (bit_cnt == BIT_LAST); // [R3]
  wire load_now = drive && (bit_cnt == 5'h00);
  // the control bit falls off the top; only the data word matters
  wire [15:0] rx_data = {rx_shift, bit_in};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_shift <= 15'h0000;
      bit_cnt <= 5'h00;
    end else if (take) begin
      rx_shift <= rx_data[14:0]; // [R3]
      bit_cnt <= packet_end ? 5'h00 : bit_cnt + 5'h01; // [R3]
    end
  end

  // -------------------------------------------------------------------
  // command decode
  // -------------------------------------------------------------------
  wire [1:0] cw_size = rx_data[SZ_MSB:SZ_LSB]; // [R22]
  wire size_ok = (cw_size != SZ_RSVD)
    && (rx_data[5:0] == CMD_LOW_ZERO); // [R22]
  wire [7:0] cw_op = rx_data[15:8];
  wire [7:0] cw_low = rx_data[SEL_MSB:0];

  wire dec_rd_gpr = rx_data[15:4] == CMD_RD_GPR; // [R11]
  wire dec_wr_gpr = rx_data[15:4] == CMD_WR_GPR; // [R11]
  wire dec_mem_rd = (cw_op == CMD_MEM_RD) && size_ok; // [R12]
  wire dec_mem_wr = (cw_op == CMD_MEM_WR) && size_ok; // [R13]
  wire dec_dump = (cw_op == CMD_DUMP) && size_ok; // [R14]
  wire dec_fill = (cw_op == CMD_FILL) && size_ok; // [R15]
  wire dec_go = rx_data == CMD_GO; // [R16]
  wire dec_nop = rx_data == CMD_NOP; // [R17]
  wire dec_rd_ctrl = rx_data == CMD_RD_CTRL; // [R18]
  wire dec_wr_ctrl = rx_data == CMD_WR_CTRL; // [R18]
  wire dec_rd_dbg = cw_op == CMD_RD_DBG; // [R19]
  wire dec_wr_dbg = cw_op == CMD_WR_DBG; // [R19]

  wire dec_legal = dec_rd_gpr | dec_wr_gpr | dec_mem_rd | dec_mem_wr
    | dec_dump | dec_fill | dec_go | dec_nop | dec_rd_ctrl
    | dec_wr_ctrl | dec_rd_dbg | dec_wr_dbg; // [R21]
  // halted class; steal and parallel classes run with the core going
  wire dec_need_halt = dec_rd_gpr | dec_wr_gpr | dec_go
    | dec_rd_ctrl | dec_wr_ctrl; // [R20]
  wire dec_is_mem = dec_mem_rd | dec_mem_wr | dec_dump | dec_fill;
  wire dec_long = cw_size == SZ_LONG;

  wire [1:0] dec_addr_words = (dec_mem_rd | dec_mem_wr | dec_rd_ctrl
    | dec_wr_ctrl) ? 2'h2 : 2'h0;
  wire [1:0] dec_data_words = (dec_wr_gpr | dec_wr_ctrl | dec_wr_dbg)
    ? 2'h2 : ((dec_mem_wr | dec_fill) ? (dec_long ? 2'h2 : 2'h1) : 2'h0);

  wire bdsp_kind_t dec_kind = dec_wr_gpr ? K_GPR_WR
    : (dec_mem_rd | dec_dump) ? K_MEM_RD
    : (dec_mem_wr | dec_fill) ? K_MEM_WR
    : dec_rd_ctrl ? K_CTRL_RD
    : dec_wr_ctrl ? K_CTRL_WR
    : dec_rd_dbg ? K_DBG_RD
    : dec_wr_dbg ? K_DBG_WR
    : K_GPR_RD;
  wire [7:0] dec_sel = (dec_rd_gpr | dec_wr_gpr)
    ? {4'h0, rx_data[GPR_SEL_MSB:0]}
    : ((dec_rd_dbg | dec_wr_dbg) ? cw_low : 8'h00);
  wire [1:0] dec_size = dec_is_mem ? cw_size : SZ_LONG;

  // -------------------------------------------------------------------
  // command outcome
  // -------------------------------------------------------------------
  bdsp_state_t state;
  logic [1:0] addr_left;
  logic [1:0] data_left;
  logic res_s;
  logic [15:0] res_word;
  logic [15:0] res_lo;
  logic [1:0] res_left;
  logic rd_chain;
  logic wr_chain;

  // a dump or fill without its opening read or write is refused
  wire dec_bad_seq = (dec_dump & ~rd_chain) | (dec_fill & ~wr_chain);
  wire cmd_illegal = ~dec_legal | dec_bad_seq; // [R21]
  wire cmd_refused = dec_need_halt & ~cpu_halted; // [R20]
  wire cmd_quick = cmd_illegal | cmd_refused | dec_nop | dec_go;
  wire [16:0] quick_rsp = cmd_illegal ? RSP_ILLEGAL
    : (cmd_refused ? RSP_BUS_ERR : RSP_DONE); // [R8]
  wire cmd_has_ext = (dec_addr_words != 2'h0) || (dec_data_words != 2'h0);
  // the last result word travels while the next command arrives
  wire cmd_slot = (state == ST_IDLE)
    || (state == ST_RESULT && res_left == 2'h0); // [R23]

  // -------------------------------------------------------------------
  // extension words and results
  // -------------------------------------------------------------------
  wire kind_mem = (req_kind == K_MEM_RD) || (req_kind == K_MEM_WR);
  wire [2:0] ext_total = {1'b0, addr_left} + {1'b0, data_left};
  wire ext_last = ext_total == 3'h1;
  wire [31:0] ext_addr = {req_addr[15:0], rx_data};
  wire align_now = kind_mem && (addr_left == 2'h1);
  wire [31:0] next_addr = !align_now ? ext_addr
    : (req_size == SZ_LONG) ? {ext_addr[31:2], 2'b00}
    : (req_size == SZ_WORD) ? {ext_addr[31:1], 1'b0}
    : ext_addr;
  wire [31:0] size_step = (req_size == SZ_LONG) ? 32'h0000_0004
    : ((req_size == SZ_WORD) ? 32'h0000_0002 : 32'h0000_0001);
  // a byte comes back in the low half; the upper byte is filled with zero
  wire [15:0] short_data = (req_size == SZ_BYTE)
    ? {8'h00, req_rdata[7:0]} : req_rdata[15:0];
  wire [16:0] resp_next = (state == ST_RESULT && res_left != 2'h0)
    ? {res_s, res_word} : RSP_NOT_READY; // [R8]

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      addr_left <= 2'h0;
      data_left <= 2'h0;
      req_valid <= 1'b0;
      req_kind <= K_GPR_RD;
      req_addr <= 32'h0000_0000;
      req_wdata <= 32'h0000_0000;
      req_size <= SZ_LONG;
      req_sel <= 8'h00;
      res_s <= 1'b1;
      res_word <= 16'h0000;
      res_lo <= 16'h0000;
      res_left <= 2'h0;
      rd_chain <= 1'b0;
      wr_chain <= 1'b0;
      resume_pulse <= 1'b0;
    end else begin
      resume_pulse <= 1'b0;
      if (load_now && state == ST_RESULT && res_left != 2'h0) begin
        res_word <= res_lo; // [R23]
        res_left <= res_left - 2'h1;
      end
      if (packet_end && cmd_slot) begin
        if (cmd_quick) begin
          state <= ST_RESULT;
          {res_s, res_word} <= quick_rsp; // [R21]
          res_left <= 2'h1;
          resume_pulse <= dec_go & ~cmd_illegal & ~cmd_refused; // [R16]
        end else begin
          req_kind <= dec_kind; // [R11] [R18] [R19]
          req_sel <= dec_sel; // [R19]
          req_size <= dec_size; // [R22]
          addr_left <= dec_addr_words;
          data_left <= dec_data_words;
          res_left <= 2'h0;
          if (dec_mem_rd) begin
            rd_chain <= 1'b1; // [R14]
            wr_chain <= 1'b0;
          end
          if (dec_mem_wr) begin
            wr_chain <= 1'b1; // [R15]
            rd_chain <= 1'b0;
          end
          if (cmd_has_ext) begin
            state <= ST_EXT;
          end else begin
            state <= ST_EXEC;
            req_valid <= 1'b1; // [R14] [R19]
          end
        end
      end else if (packet_end && state == ST_EXT) begin
        if (addr_left != 2'h0) begin
          req_addr <= next_addr;
          addr_left <= addr_left - 2'h1;
        end else begin
          req_wdata <= {req_wdata[15:0], rx_data};
          data_left <= data_left - 2'h1;
        end
        if (ext_last) begin
          state <= ST_EXEC;
          req_valid <= 1'b1; // [R12] [R13]
        end
      end else if (state == ST_EXEC && req_done) begin
        req_valid <= 1'b0;
        state <= ST_RESULT;
        res_left <= 2'h1;
        if (kind_mem) begin
          req_addr <= req_addr + size_step; // [R14] [R15]
        end
        if (req_error) begin
          {res_s, res_word} <= RSP_BUS_ERR; // [R8]
        end else if (req_kind[0]) begin
          {res_s, res_word} <= RSP_DONE; // [R8]
        end else if (req_size == SZ_LONG) begin
          res_s <= 1'b0;
          res_word <= req_rdata[31:16];
          res_lo <= req_rdata[15:0];
          res_left <= 2'h2;
        end else begin
          res_s <= 1'b0;
          res_word <= short_data; // [R12]
        end
      end
    end
  end

  // -------------------------------------------------------------------
  // transmit shifter
  // -------------------------------------------------------------------
  // the reply is loaded right after a packet ends, so the host never has to
  // wait out the turnaround while no core, bus or debug unit access is pending
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tx_shift <= RSP_NOT_READY;
    end else if (load_now) begin
      tx_shift <= resp_next; // [R7] [R23]
    end else if (drive) begin
      tx_shift <= {tx_shift[15:0], 1'b0}; // [R6]
    end
  end

  assign serial_debug_output = tx_shift[16]; // [R3]

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  localparam int TURN_LIM = TURN_CYCLES - 1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_dso_on_step: assert property ( // [R6]
    !drive |=> $stable(serial_debug_output))
    else $error("link output moved outside the output step");

  a_reply_turnaround: assert property ( // [R7]
    packet_end |-> ##[1:TURN_LIM] load_now)
    else $error("reply not loaded within the turnaround");

  a_illegal_reply: assert property ( // [R21]
    packet_end && cmd_slot && cmd_illegal |=>
      state == ST_RESULT && {res_s, res_word} == RSP_ILLEGAL && !req_valid)
    else $error("illegal command not answered as illegal");

  a_halt_guard: assert property ( // [R20]
    packet_end && cmd_slot && dec_legal && dec_need_halt && !cpu_halted
      |=> {res_s, res_word} == RSP_BUS_ERR && !req_valid && !resume_pulse)
    else $error("halted-class command ran on a running core");

  a_resume_halted: assert property ( // [R16]
    resume_pulse |-> $past(cpu_halted) && state == ST_RESULT
      && {res_s, res_word} == RSP_DONE)
    else $error("resume issued without a halted core");

  a_null_quiet: assert property ( // [R17]
    packet_end && cmd_slot && dec_nop |=>
      !req_valid && !resume_pulse ##1 !req_valid)
    else $error("null command caused an access");

  a_mem_size_ok: assert property ( // [R22]
    $rose(req_valid) && kind_mem |-> req_size != SZ_RSVD)
    else $error("memory access issued with reserved size");

  a_dbg_select: assert property ( // [R19]
    packet_end && cmd_slot && dec_rd_dbg && !cmd_quick |=>
      req_valid && req_kind == K_DBG_RD && req_sel == $past(cw_low))
    else $error("debug unit read lost its register code");

  a_dump_chain: assert property ( // [R14]
    packet_end && cmd_slot && dec_dump && !rd_chain |=>
      {res_s, res_word} == RSP_ILLEGAL)
    else $error("dump accepted without an opening read");

  a_long_pair: assert property ( // [R23]
    state == ST_EXEC && req_done && !req_error && !req_kind[0]
      && req_size == SZ_LONG |=> res_left == 2'h2 && !res_s
      && res_word == $past(req_rdata[31:16]))
    else $error("long result not returned high word first");

  a_ext_align: assert property ( // [R12]
    packet_end && state == ST_EXT && align_now && req_size != SZ_BYTE
      |=> !req_addr[0] && (req_size == SZ_WORD || !req_addr[1]))
    else $error("memory address not aligned to its size");

  a_req_hold: assert property ( // [R13]
    req_valid && !req_done |=> req_valid && $stable(req_addr)
      && $stable(req_wdata) && $stable(req_kind) && $stable(req_size))
    else $error("access request changed before it was answered");

  a_resume_single: assert property ( // [R16]
    resume_pulse |=> !resume_pulse)
    else $error("resume pulse wider than one cycle");

endmodule
`default_nettype wire

// File: shared/bdsp_pkg.sv
// Constants and types shared by the background debug serial port.
`default_nettype none
// ---------------------------------------------------------------------
// What this block does
// [R1] Sample link clock and data every core edge
// [R2] Host drives link clock, at most one fifth
// [R3] Packets are 17 bits, MSB first, full duplex
// [R4] Host holds link clock low between bits
// [R5] Host frames packets by counting clocks
// [R6] Two sync cycles, state change, then output
// [R7] Ready for next transfer within 32 cycles
// [R8] Responses carry the documented status codes
// [R9] Host sends control bit as zero
// [R10] Host avoids commands during debug writes
// [R11] Decode general register read and write
// [R12] Decode memory reads by size, stealing cycles
// [R13] Decode memory writes by size, stealing cycles
// [R14] Dump reads next operand after a read
// [R15] Fill writes next operand after a write
// [R16] Resume restarts execution, only while halted
// [R17] Null command does nothing
// [R18] Decode system control register read, write
// [R19] Decode debug unit register read, write
// [R20] Halted, steal and parallel command classes
// [R21] Unknown commands answer illegal, do nothing
// [R22] Command word fields: operation, direction, size
// [R23] Each reply answers the previous command
// [R24] Host resends a command answered illegal
// ---------------------------------------------------------------------
package bdsp_pkg;

  // -------------------------------------------------------------------
  // framing and timing
  // -------------------------------------------------------------------
  localparam int PKT_BITS = 17;
  localparam logic [4:0] BIT_LAST = 5'h10;
  localparam int TURN_CYCLES = 32;

  // -------------------------------------------------------------------
  // response packets, status bit on top
  // -------------------------------------------------------------------
  localparam logic [16:0] RSP_NOT_READY = 17'h10000;
  localparam logic [16:0] RSP_BUS_ERR = 17'h10001;
  localparam logic [16:0] RSP_ILLEGAL = 17'h1FFFF;
  localparam logic [16:0] RSP_DONE = 17'h0FFFF;

  // -------------------------------------------------------------------
  // command word fields
  // -------------------------------------------------------------------
  localparam int SZ_MSB = 7;
  localparam int SZ_LSB = 6;
  localparam int SEL_MSB = 7;
  localparam int GPR_SEL_MSB = 3;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_RSVD = 2'h3;
  localparam logic [5:0] CMD_LOW_ZERO = 6'h00;

  // -------------------------------------------------------------------
  // command codes
  // -------------------------------------------------------------------
  localparam logic [11:0] CMD_RD_GPR = 12'h218;
  localparam logic [11:0] CMD_WR_GPR = 12'h208;
  localparam logic [7:0] CMD_MEM_RD = 8'h19;
  localparam logic [7:0] CMD_MEM_WR = 8'h18;
  localparam logic [7:0] CMD_DUMP = 8'h1D;
  localparam logic [7:0] CMD_FILL = 8'h1C;
  localparam logic [15:0] CMD_GO = 16'h0C00;
  localparam logic [15:0] CMD_NOP = 16'h0000;
  localparam logic [15:0] CMD_RD_CTRL = 16'h2980;
  localparam logic [15:0] CMD_WR_CTRL = 16'h2880;
  localparam logic [7:0] CMD_RD_DBG = 8'h2D;
  localparam logic [7:0] CMD_WR_DBG = 8'h2C;

  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXT = 2'b01,
    ST_EXEC = 2'b10,
    ST_RESULT = 2'b11
  } bdsp_state_t;

  // bit 0 set marks a write kind
  typedef enum logic [2:0] {
    K_GPR_RD = 3'b000,
    K_GPR_WR = 3'b001,
    K_MEM_RD = 3'b010,
    K_MEM_WR = 3'b011,
    K_CTRL_RD = 3'b100,
    K_CTRL_WR = 3'b101,
    K_DBG_RD = 3'b110,
    K_DBG_WR = 3'b111
  } bdsp_kind_t;

endpackage
`default_nettype wire

// File: hdl/bdsp_bit_sync.sv
// Link pin synchroniser and per-bit phase strobes.
`default_nettype none
module bdsp_bit_sync
  import bdsp_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // link pins
  input wire logic serial_debug_clock,
  input wire logic serial_debug_input,
  // bit phase strobes
  output logic take,
  output logic drive,
  output logic bit_value
);

  // -------------------------------------------------------------------
  // elaboration check
  // -------------------------------------------------------------------
  if (SYNC_STAGES < 2) begin : g_bad_stages
    $error("bdsp_bit_sync needs at least two stages");
  end

  // -------------------------------------------------------------------
  // synchronisers
  // -------------------------------------------------------------------
  logic [SYNC_STAGES-1:0] clk_sync;
  logic [SYNC_STAGES-1:0] din_sync;
  logic clk_seen;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clk_sync <= '0;
      din_sync <= '0;
      clk_seen <= 1'b0;
      drive <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[SYNC_STAGES-2:0], serial_debug_clock}; // [R1]
      din_sync <= {din_sync[SYNC_STAGES-2:0], serial_debug_input}; // [R1]
      clk_seen <= clk_sync[SYNC_STAGES-1];
      drive <= take; // [R6]
    end
  end

  // the bit is taken on the third high cycle, the output moves on the fourth
  assign take = clk_sync[SYNC_STAGES-1] & ~clk_seen; // [R6]
  assign bit_value = din_sync[SYNC_STAGES-1];

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_take_high_only: assert property ( // [R1]
    take |-> clk_sync[SYNC_STAGES-1] ##1 !take)
    else $error("bit taken while link clock not high");

  a_drive_follows: assert property ( // [R6]
    take |=> drive ##1 !drive)
    else $error("output step not one cycle after bit take");

endmodule
`default_nettype wire

// File: test/bdsp_host_model.sv
// Serial master model of the host debugger for the debug serial port.
`default_nettype none
module bdsp_host_model
  import bdsp_pkg::*;
(
  // clock
  input wire logic core_clk,
  // link pins
  output var logic serial_debug_clock,
  output var logic serial_debug_input,
  input wire logic serial_debug_output
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serial_debug_clock = 1'b0;
    serial_debug_input = 1'b1;
  end

  // -------------------------------------------------------------------
  // one packet, 8 core cycles a bit: 4 high, 4 low
  // -------------------------------------------------------------------
  // no debug-write instruction runs beside this model
  task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
    for (int i = PKT_BITS - 1; i >= 0; i--) begin
      @(posedge core_clk);
      rx[i] = serial_debug_output;
      serial_debug_clock <= 1'b1;
      serial_debug_input <= tx[i];
      repeat (4) @(posedge core_clk);
      // low long enough to be seen, data turns to noise
      serial_debug_clock <= 1'b0;
      serial_debug_input <= ~tx[i];
      repeat (3) @(posedge core_clk);
    end
    // framing is by count alone, then a turnaround gap
    repeat (TURN_CYCLES) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: test/bdsp_top_tb_top.sv
// Testbench for the background debug serial port.
`default_nettype none
module bdsp_top_tb_top
  import bdsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] RDATA = 32'hA5C396E1;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, sdin, sdout, cpu_halted, resume_pulse, req_valid;
  logic req_done = 1'b0;
  logic req_error = 1'b0;
  logic [31:0] req_addr, req_wdata, req_rdata;
  logic [1:0] req_size;
  logic [7:0] req_sel;
  bdsp_kind_t req_kind, g_kind;
  logic [31:0] g_addr, g_wdata;
  logic [1:0] g_size;
  logic [7:0] g_sel;
  logic err_mode;
  int failures = 0;
  int check_count = 0;
  int n_req = 0;
  int n_res = 0;
  int dly = 0;
  int tnum = 0;

  always #12.5 core_clk = ~core_clk;

  bdsp_top u_bdsp_top (.core_clk(core_clk), .reset_n(reset_n),
    .serial_debug_clock(sclk), .serial_debug_input(sdin),
    .serial_debug_output(sdout), .cpu_halted(cpu_halted),
    .resume_pulse(resume_pulse), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_size(req_size), .req_sel(req_sel), .req_done(req_done),
    .req_error(req_error), .req_rdata(req_rdata));

  bdsp_host_model u_bdsp_host_model (.core_clk(core_clk),
    .serial_debug_clock(sclk), .serial_debug_input(sdin),
    .serial_debug_output(sdout));

  // -------------------------------------------------------------------
  // access responder: answers each request five cycles late
  // -------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (resume_pulse === 1'b1) n_res <= n_res + 1;
    if (req_valid !== 1'b1 || req_done) begin
      dly <= 0;
      req_done <= 1'b0;
    end else if (dly == 4) begin
      req_done <= 1'b1;
      req_error <= err_mode;
      n_req <= n_req + 1;
      g_kind <= req_kind;
      {g_addr, g_wdata} <= {req_addr, req_wdata};
      {g_size, g_sel} <= {req_size, req_sel};
    end else dly <= dly + 1;
  end

  task automatic wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // -------------------------------------------------------------------
  // one command: send its words, poll with null commands, check all
  // -------------------------------------------------------------------
  task automatic run(input int n, input logic [15:0] w [5],
      input logic hlt, err, input logic [16:0] rep, input int nreq, nres,
      input bdsp_kind_t k, input logic [31:0] a, wd, input logic [1:0] sz,
      input logic [7:0] sel);
    int r0, s0, i;
    logic [16:0] rx;
    r0 = n_req;
    s0 = n_res;
    cpu_halted <= hlt;
    err_mode <= err;
    @(posedge core_clk);
    // control bit always sent clear
    for (i = 0; i < n; i++) u_bdsp_host_model.xfer({1'b0, w[i]}, rx);
    rx = RSP_NOT_READY;
    i = 0;
    while (rx === RSP_NOT_READY && i < 20) begin
      u_bdsp_host_model.xfer(17'h00000, rx);
      i++;
    end
    check("reply", {15'h0, rx}, {15'h0, rep});
    if (nreq == 1 && !err && !k[0] && sz === SZ_LONG) begin
      u_bdsp_host_model.xfer(17'h00000, rx);
      check("reply_lo", {15'h0, rx}, {16'h0, RDATA[15:0]});
    end
    check("req_count", 32'(n_req - r0), 32'(nreq));
    check("resume_count", 32'(n_res - s0), 32'(nres));
    if (nreq == 1) begin
      check("kind", {29'h0, g_kind}, {29'h0, k});
      check("size", {30'h0, g_size}, {30'h0, sz});
      if (k inside {K_MEM_RD, K_MEM_WR, K_CTRL_RD, K_CTRL_WR})
        check("addr", g_addr, a);
      if (k[0])
        check("wdata", g_wdata, wd);
      if (k inside {K_GPR_RD, K_GPR_WR, K_DBG_RD, K_DBG_WR})
        check("sel", {24'h0, g_sel}, {24'h0, sel});
    end
    tnum++;
    $display("test %0d done", tnum);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  initial begin
    {cpu_halted, err_mode} = 2'h0;
    req_rdata = RDATA;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check("idle_out", {31'h0, sdout}, 32'h1);
    check("idle_req", {31'h0, req_valid}, 32'h0);
    run(1, '{16'h0000, 0, 0, 0, 0}, 0, 0, RSP_DONE, 0, 0, K_GPR_RD,
      0, 0, 0, 0);
    run(1, '{16'h3000, 0, 0, 0, 0}, 0, 0, RSP_ILLEGAL, 0, 0, K_GPR_RD,
      0, 0, 0, 0);
    run(1, '{16'h19C0, 0, 0, 0, 0}, 0, 0, RSP_ILLEGAL, 0, 0, K_GPR_RD,
      0, 0, 0, 0);
    run(1, '{16'h1D40, 0, 0, 0, 0}, 0, 0, RSP_ILLEGAL, 0, 0, K_GPR_RD,
      0, 0, 0, 0);
    run(1, '{16'h1C40, 0, 0, 0, 0}, 0, 0, RSP_ILLEGAL, 0, 0, K_GPR_RD,
      0, 0, 0, 0);
    run(3, '{16'h1940, 16'h1234, 16'h5679, 0, 0}, 0, 0, 17'h096E1, 1, 0,
      K_MEM_RD, 32'h12345678, 0, SZ_WORD, 0);
    // the dump refused above is sent again now that a read opened the block
    run(1, '{16'h1D40, 0, 0, 0, 0}, 0, 0, 17'h096E1, 1, 0,
      K_MEM_RD, 32'h1234567A, 0, SZ_WORD, 0);
    run(5, '{16'h1880, 16'hCAFE, 16'h0003, 16'h1122, 16'h3344}, 0, 0,
      RSP_DONE, 1, 0, K_MEM_WR, 32'hCAFE0000, 32'h11223344, SZ_LONG,
      0);
    run(3, '{16'h1C80, 16'h5566, 16'h7788, 0, 0}, 0, 0, RSP_DONE, 1, 0,
      K_MEM_WR, 32'hCAFE0004, 32'h55667788, SZ_LONG, 0);
    run(3, '{16'h1900, 16'h0000, 16'h0010, 0, 0}, 0, 1, RSP_BUS_ERR, 1, 0,
      K_MEM_RD, 32'h00000010, 0, SZ_BYTE, 0);
    run(3, '{16'h1900, 16'h0000, 16'h0011, 0, 0}, 0, 0, 17'h000E1, 1, 0,
      K_MEM_RD, 32'h00000011, 0, SZ_BYTE, 0);
    run(1, '{16'h2185, 0, 0, 0, 0}, 0, 0, RSP_BUS_ERR, 0, 0, K_GPR_RD,
      0, 0, 0, 0);
    run(1, '{16'h2185, 0, 0, 0, 0}, 1, 0, 17'h0A5C3, 1, 0, K_GPR_RD,
      0, 0, SZ_LONG, 8'h05);
    run(3, '{16'h208A, 16'h0102, 16'h0304, 0, 0}, 1, 0, RSP_DONE, 1, 0,
      K_GPR_WR, 0, 32'h01020304, SZ_LONG, 8'h0A);
    run(3, '{16'h2980, 16'h0000, 16'h0801, 0, 0}, 1, 0, 17'h0A5C3, 1, 0,
      K_CTRL_RD, 32'h00000801, 0, SZ_LONG, 0);
    run(5, '{16'h2880, 16'h0000, 16'h0801, 16'hDEAD, 16'hBEEF}, 1, 0,
      RSP_DONE, 1, 0, K_CTRL_WR, 32'h00000801, 32'hDEADBEEF, SZ_LONG,
      0);
    run(1, '{16'h2D07, 0, 0, 0, 0}, 0, 0, 17'h0A5C3, 1, 0, K_DBG_RD,
      0, 0, SZ_LONG, 8'h07);
    run(3, '{16'h2C09, 16'h1357, 16'h9BDF, 0, 0}, 0, 0, RSP_DONE, 1, 0,
      K_DBG_WR, 0, 32'h13579BDF, SZ_LONG, 8'h09);
    run(1, '{16'h0C00, 0, 0, 0, 0}, 0, 0, RSP_BUS_ERR, 0, 0, K_GPR_RD,
      0, 0, 0, 0);
    run(1, '{16'h0C00, 0, 0, 0, 0}, 1, 0, RSP_DONE, 0, 1, K_GPR_RD,
      0, 0, 0, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
